// >>> hw/usdp_pkg.sv
// Constants and carrier types for the serial transceiver data paths.
// Assumes one 10 MHz system clock; bit timing arrives as one-cycle enables.
// What this block does
// - Buffer-empty flag high when transmit buffer empty, low while it holds data.
// - Buffer-empty interrupt requested while its enable, the global enable and flag are set.
// - Data register write loads transmit buffer and clears buffer-empty flag.
// - Complete flag sets when frame sent and transmit buffer is empty.
// - Complete flag clears on interrupt service or software write of one.
// - Complete interrupt requested when enabled, globally enabled and complete flag is set.
// - Upper parity mode bit inserts parity after data, before stop bit.
// - Transmitter stays active after disable until all data sent, then releases pin.
// - Receive enable takes over the receive pin as serial input.
// - Synchronous mode uses external transfer clock as receive bit clock.
// - Reception starts on valid start bit; bits sampled until first stop bit.
// - Receiver ignores second stop bit, checks only the first.
// - After first stop bit, frame moves from shift register into receive buffer.
// - Unused upper data bits read as zero for short characters.
// - Ninth bit and error flags stored per entry; data read advances FIFO.
// - Frame is low start, 5 to 9 data bits LSB first, parity, high stops.
// - Parity is XOR of data bits, inverted for odd.
// - Shift register loads from buffer when idle or right after last stop bit.
// - Receive complete flag is one while unread data remain.
package usdp_pkg;
   localparam int           USDP_DW        = 9;
   localparam int           USDP_FIFO_D    = 2;
   localparam logic [2:0]   USDP_CS_9BIT   = 3'h7;
   localparam logic [2:0]   USDP_CS_BASE   = 3'h5;
   localparam logic [3:0]   USDP_BITS_MIN  = 4'h5;
   localparam logic [3:0]   USDP_BITS_9    = 4'h9;

   typedef struct packed {
      logic [2:0] char_size;
      logic [1:0] parity_mode;
      logic       two_stop;
      logic       sync_mode;
   } usdp_cfg_t;

   typedef struct packed {
      logic [8:0] data;
      logic       frame_error_flag;
      logic       parity_error_flag;
      logic       overrun_flag;
   } usdp_rx_entry_t;

   // Data width from character size
   function automatic logic [3:0] usdp_nbits(input logic [2:0] cs);
      if (cs == USDP_CS_9BIT)
         return USDP_BITS_9;
      else if (cs > 3'h3)
         return 4'h8;
      else
         return USDP_BITS_MIN + {2'h0, cs[1:0]};
   endfunction : usdp_nbits

   function automatic logic usdp_parity(input logic [8:0] d, input logic [3:0] n, input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < USDP_DW; i++)
         if (i < int'(n))
            p = p ^ d[i];
      return p;
   endfunction : usdp_parity

   function automatic logic [8:0] usdp_mask(input logic [8:0] d, input logic [3:0] n);
      logic [8:0] m;
      m = '0;
      for (int i = 0; i < USDP_DW; i++)
         if (i < int'(n))
            m[i] = d[i];
      return m;
   endfunction : usdp_mask
endpackage : usdp_pkg

// >>> hw/usdp_rx.sv
// Receive shift path and two-entry receive FIFO.
// Assumes start bit already qualified by the clock recovery; bit_en marks sample points.
`timescale 1ns/100ps
`default_nettype none
module usdp_rx (
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   input  wire usdp_pkg::usdp_cfg_t      cfg,
   input  wire logic                     rx_enable,
   input  wire logic                     bit_en,
   input  wire logic                     start_valid,
   input  wire logic                     serial_in_pin,
   input  wire logic                     data_read,
   output logic                          rx_complete_flag,
   output usdp_pkg::usdp_rx_entry_t      rx_head
);
   import usdp_pkg::*;

   typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} usdp_rxst_t;

   typedef struct packed {
      usdp_rxst_t     st;
      logic [3:0]     cnt;
      logic [8:0]     sh;
      logic           perr;
      logic           pend;
      usdp_rx_entry_t pend_e;
      logic           ovr;
      usdp_rx_entry_t [USDP_FIFO_D-1:0] mem;
      logic [1:0]     level;
   } usdp_rx_state_t;

   usdp_rx_state_t s_q, s_d;
   logic [3:0]     nb;
   logic           push;
   usdp_rx_entry_t new_e;

   assign nb = usdp_nbits(cfg.char_size);

   always_comb
   begin
      s_d   = s_q;
      push  = 1'b0;
      new_e = '0;
      if (data_read && s_q.level != 2'h0)
      begin
         s_d.mem[0] = s_q.mem[1];
         s_d.level  = s_q.level - 2'h1;
      end
      if (bit_en)
      begin
         unique case (s_q.st)
            RX_IDLE:
            begin
               if (start_valid && !serial_in_pin)
               begin
                  s_d.st   = RX_DATA;
                  s_d.cnt  = '0;
                  s_d.sh   = '0;
                  // Overrun when full and a frame is still waiting
                  if (s_q.pend)
                     s_d.ovr = 1'b1;
               end
            end
            RX_DATA:
            begin
               s_d.sh[s_q.cnt] = serial_in_pin;
               s_d.cnt         = s_q.cnt + 4'h1;
               if (s_q.cnt + 4'h1 == nb)
                  s_d.st = cfg.parity_mode[1] ? RX_PAR : RX_STOP;
            end
            RX_PAR:
            begin
               s_d.perr = usdp_parity(s_q.sh, nb, cfg.parity_mode[0]) != serial_in_pin;
               s_d.st   = RX_STOP;
            end
            RX_STOP:
            begin
               new_e.data              = usdp_mask(s_q.sh, nb);
               new_e.frame_error_flag  = !serial_in_pin;
               new_e.parity_error_flag = cfg.parity_mode[1] & s_q.perr;
               new_e.overrun_flag      = s_q.ovr;
               push                    = 1'b1;
               s_d.perr                = 1'b0;
               s_d.st                  = RX_IDLE;
            end
         endcase
      end
      if (push)
      begin
         s_d.pend   = 1'b1;
         s_d.pend_e = new_e;
      end
      // waiting frame enters FIFO when room
      if (s_q.pend && s_d.level < 2'(USDP_FIFO_D) && !push)
      begin
         s_d.mem[s_d.level[0]] = s_q.pend_e;
         s_d.level = s_d.level + 2'h1;
         s_d.pend  = 1'b0;
         s_d.ovr   = 1'b0;
      end
      if (!rx_enable)
      begin
         s_d       = '0;
         s_d.st    = RX_IDLE;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign rx_complete_flag = s_q.level != 2'h0;
   assign rx_head          = s_q.level != 2'h0 ? s_q.mem[0] : '0;
endmodule : usdp_rx
`default_nettype wire

// >>> hw/usdp_top.sv
// Transmit path, flags, interrupts and receive path wiring.
// Assumes baud enables come from an outside divider; one clock, plain control ports.
`timescale 1ns/100ps
`default_nettype none
module usdp_top (
   input  wire logic                     clk_sys,
   input  wire logic                     nrst,
   input  wire usdp_pkg::usdp_cfg_t      cfg,
   input  wire logic                     tx_enable,
   input  wire logic                     rx_enable,
   input  wire logic                     tx_buffer_empty_irq_enable,
   input  wire logic                     tx_complete_irq_enable,
   input  wire logic                     global_irq_enable,
   input  wire logic                     baud_en,
   input  wire logic                     ext_transfer_clock_pin,
   input  wire logic                     data_write,
   input  wire logic [7:0]               data_wdata,
   input  wire logic                     tx_ninth_bit,
   input  wire logic                     tx_complete_clear,
   input  wire logic                     tx_complete_ack,
   input  wire logic                     data_read,
   input  wire logic                     start_valid,
   input  wire logic                     serial_in_pin,
   output logic [7:0]                    data_rdata,
   output logic                          rx_ninth_bit,
   output logic                          frame_error_flag,
   output logic                          parity_error_flag,
   output logic                          overrun_flag,
   output logic                          rx_complete_flag,
   output logic                          tx_buffer_empty_flag,
   output logic                          tx_complete_flag,
   output logic                          tx_buffer_empty_irq,
   output logic                          tx_complete_irq,
   output logic                          serial_out_pin,
   output logic                          tx_pin_owned,
   output logic                          rx_pin_owned
);
   import usdp_pkg::*;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2, TX_END} usdp_txst_t;

   typedef struct packed {
      usdp_txst_t st;
      logic [3:0] cnt;
      logic [8:0] buf_d;
      logic       buf_full;
      logic [8:0] sh;
      logic       out;
      logic       done;
      logic       active;
      logic       xck_d;
   } usdp_top_state_t;

   usdp_top_state_t s_q, s_d;
   logic [1:0]          rst_sync_q;
   logic                rst_n;
   logic [3:0]          nb;
   logic                bit_en;
   logic                xck_rise;
   logic                load;
   usdp_rx_entry_t      head;

   // Reset release through two flops, kept apart from the state record
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         rst_sync_q <= '0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   assign nb       = usdp_nbits(cfg.char_size);
   assign xck_rise = ext_transfer_clock_pin & ~s_q.xck_d;
   assign bit_en   = cfg.sync_mode ? xck_rise : baud_en;

   always_comb
   begin
      s_d          = s_q;
      s_d.xck_d    = ext_transfer_clock_pin;
      load         = 1'b0;
      if (data_write)
      begin
         s_d.buf_d    = {tx_ninth_bit, data_wdata};
         s_d.buf_full = 1'b1;
      end
      // clear on write of one or service
      if (tx_complete_clear || tx_complete_ack)
         s_d.done = 1'b0;
      if (bit_en && s_q.active)
      begin
         unique case (s_q.st)
            TX_IDLE:
               load = s_q.buf_full;
            TX_START:
            begin
               s_d.out = 1'b0;
               s_d.cnt = '0;
               s_d.st  = TX_DATA;
            end
            TX_DATA:
            begin
               s_d.out = s_q.sh[s_q.cnt];
               s_d.cnt = s_q.cnt + 4'h1;
               if (s_q.cnt + 4'h1 == nb)
                  s_d.st = cfg.parity_mode[1] ? TX_PAR : TX_STOP1;
            end
            TX_PAR:
            begin
               s_d.out = usdp_parity(s_q.sh, nb, cfg.parity_mode[0]);
               s_d.st  = TX_STOP1;
            end
            TX_STOP1:
            begin
               s_d.out = 1'b1;
               s_d.st  = cfg.two_stop ? TX_STOP2 : TX_END;
            end
            TX_STOP2:
            begin
               s_d.out = 1'b1;
               s_d.st  = TX_END;
            end
            // Last stop bit has now left the line
            TX_END:
               s_d.st = TX_IDLE;
         endcase
         if (s_q.st == TX_END)
         begin
            if (s_q.buf_full && !data_write)
               load = 1'b1;
            else if (!s_q.buf_full && !data_write)
               s_d.done = 1'b1;
         end
      end
      if (load)
      begin
         s_d.sh       = usdp_mask(s_q.buf_d, nb);
         s_d.buf_full = data_write;
         s_d.st       = TX_START;
         // Back-to-back frame: start bit follows the stop with no gap
         if (s_q.st == TX_END)
         begin
            s_d.out = 1'b0;
            s_d.cnt = '0;
            s_d.st  = TX_DATA;
         end
      end
      if (tx_enable)
         s_d.active = 1'b1;
      else if (s_q.st == TX_IDLE && !s_q.buf_full)
         s_d.active = 1'b0;
      if (!s_d.active)
         s_d.out = 1'b1;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q.st     <= TX_IDLE;
         s_q.cnt    <= '0;
         s_q.buf_d  <= '0;
         s_q.buf_full <= 1'b0;
         s_q.sh     <= '0;
         s_q.out    <= 1'b1;
         s_q.done   <= 1'b0;
         s_q.active <= 1'b0;
         s_q.xck_d  <= 1'b0;
      end
      else
      begin
         s_q.st     <= s_d.st;
         s_q.cnt    <= s_d.cnt;
         s_q.buf_d  <= s_d.buf_d;
         s_q.buf_full <= s_d.buf_full;
         s_q.sh     <= s_d.sh;
         s_q.out    <= s_d.out;
         s_q.done   <= s_d.done;
         s_q.active <= s_d.active;
         s_q.xck_d  <= s_d.xck_d;
      end
   end

   usdp_rx u_rx (
      .clk_sys          (clk_sys),
      .rst_n            (rst_n),
      .cfg              (cfg),
      .rx_enable        (rx_enable),
      .bit_en           (bit_en),
      .start_valid      (start_valid),
      .serial_in_pin    (serial_in_pin),
      .data_read        (data_read),
      .rx_complete_flag (rx_complete_flag),
      .rx_head          (head)
   );

   assign tx_buffer_empty_flag = ~s_q.buf_full;
   assign tx_complete_flag     = s_q.done;
   assign tx_buffer_empty_irq  = tx_buffer_empty_irq_enable & ~s_q.buf_full & global_irq_enable;
   assign tx_complete_irq      = tx_complete_irq_enable & s_q.done & global_irq_enable;
   assign serial_out_pin       = s_q.out;
   assign tx_pin_owned         = s_q.active;
   assign rx_pin_owned         = rx_enable;
   assign data_rdata           = head.data[7:0];
   assign rx_ninth_bit         = head.data[8];
   assign frame_error_flag     = head.frame_error_flag;
   assign parity_error_flag    = head.parity_error_flag;
   assign overrun_flag         = head.overrun_flag;
endmodule : usdp_top
`default_nettype wire

// >>> verification/usdp_top_asserts.sv
// Port checker for the transceiver top.
// Assumes binding to usdp_top; one clock, reset low.
`timescale 1ns/100ps
`default_nettype none
module usdp_top_asserts (
   input wire logic                clk_sys,
   input wire logic                nrst,
   input wire usdp_pkg::usdp_cfg_t cfg,
   input wire logic                rx_enable,
   input wire logic                tx_buffer_empty_irq_enable,
   input wire logic                tx_complete_irq_enable,
   input wire logic                global_irq_enable,
   input wire logic                data_write,
   input wire logic                tx_complete_clear,
   input wire logic                tx_complete_ack,
   input wire logic [7:0]          data_rdata,
   input wire logic                rx_complete_flag,
   input wire logic                tx_buffer_empty_flag,
   input wire logic                tx_complete_flag,
   input wire logic                tx_buffer_empty_irq,
   input wire logic                tx_complete_irq,
   input wire logic                serial_out_pin,
   input wire logic                tx_pin_owned,
   input wire logic                rx_pin_owned
);
   import usdp_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_clear_req;
      tx_complete_ack || tx_complete_clear;
   endsequence
   sequence s_clear_done;
      ##1 !tx_complete_flag;
   endsequence
   wr_clears_a: assert property (data_write |=> !tx_buffer_empty_flag)
      else $error("empty flag kept after write");
   empty_irq_a: assert property (
      tx_buffer_empty_irq == (tx_buffer_empty_flag && tx_buffer_empty_irq_enable && global_irq_enable))
      else $error("empty irq wrong");
   done_irq_a: assert property (
      tx_complete_irq == (tx_complete_flag && tx_complete_irq_enable && global_irq_enable))
      else $error("complete irq wrong");
   done_clear_a: assert property (s_clear_req |-> s_clear_done)
      else $error("complete flag not cleared");
   done_empty_a: assert property ($rose(tx_complete_flag) |-> tx_buffer_empty_flag)
      else $error("complete with data pending");
   tx_release_a: assert property ($fell(tx_pin_owned) |-> tx_buffer_empty_flag)
      else $error("pin released with data pending");
   idle_high_a: assert property (!tx_pin_owned |-> serial_out_pin)
      else $error("idle line not high");
   rx_pin_a: assert property (rx_pin_owned == rx_enable)
      else $error("receive pin ownership wrong");
   rx_flush_a: assert property (!rx_enable |=> !rx_complete_flag)
      else $error("buffer not flushed");
   short_char_a: assert property (cfg.char_size < 3'h3 |-> (data_rdata >> (3'h5 + cfg.char_size)) == 8'h0)
      else $error("upper bit not zero");
endmodule : usdp_top_asserts
bind usdp_top usdp_top_asserts i_usdp_top_asserts (.clk_sys, .nrst, .cfg, .rx_enable,
   .tx_buffer_empty_irq_enable, .tx_complete_irq_enable, .global_irq_enable, .data_write,
   .tx_complete_clear, .tx_complete_ack, .data_rdata, .rx_complete_flag, .tx_buffer_empty_flag,
   .tx_complete_flag, .tx_buffer_empty_irq, .tx_complete_irq, .serial_out_pin, .tx_pin_owned, .rx_pin_owned);
`default_nettype wire

// >>> verification/usdp_remote.sv
// Remote serial transceiver model on both lines.
// Assumes baud_en pulses once a bit; frame_len counts bits after start.
`timescale 1ns/100ps
`default_nettype none
module usdp_remote (
   input  wire logic       clk_sys,
   input  wire logic       baud_en,
   input  wire logic       serial_out_pin,
   input  wire logic [3:0] frame_len,
   output var  logic       serial_in_pin,
   output var  logic       start_valid
);
   logic [11:0] word;
   int          cnt = 0;
   logic [11:0] got [$];
   initial
   begin
      serial_in_pin = 1'h1;
      start_valid   = 1'h0;
   end
   always @(posedge clk_sys)
      if (baud_en && cnt > 0)
      begin
         word[cnt - 1] = serial_out_pin;
         cnt++;
         if (cnt > int'(frame_len))
         begin
            got.push_back(word);
            cnt = 0;
         end
      end
      else if (baud_en && !serial_out_pin)
      begin
         word = '0;
         cnt  = 1;
      end
   task automatic send(input logic [11:0] w, input int n);
      @(posedge clk_sys iff baud_en);
      serial_in_pin <= 1'h0;
      start_valid   <= 1'h1;
      @(posedge clk_sys iff baud_en);
      start_valid <= 1'h0;
      for (int i = 0; i < n; i++)
      begin
         serial_in_pin <= w[i];
         @(posedge clk_sys iff baud_en);
      end
      serial_in_pin <= 1'h1;
   endtask : send
endmodule : usdp_remote
`default_nettype wire

// >>> verification/uart_tx_rx_datapath_flags_test.sv
// Self-checking bench for the transceiver data paths.
// Assumes usdp_remote on the lines and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module uart_tx_rx_datapath_flags_test;
   import usdp_pkg::*;
   usdp_cfg_t  cfg = '0;
   logic       clk_sys = 0, nrst = 0, baud_en = 0, ext_transfer_clock_pin = 0, tx_enable = 1, rx_enable = 0;
   logic       global_irq_enable = 1, tx_buffer_empty_irq_enable = 1, tx_complete_irq_enable = 1;
   logic       data_write = 0, data_read = 0, tx_ninth_bit = 0, tx_complete_clear = 0, tx_complete_ack = 0;
   logic       start_valid, serial_in_pin, rx_ninth_bit, frame_error_flag, parity_error_flag, overrun_flag;
   logic       rx_complete_flag, tx_buffer_empty_flag, tx_complete_flag, tx_buffer_empty_irq, tx_complete_irq;
   logic       serial_out_pin, tx_pin_owned, rx_pin_owned;
   logic [7:0] data_wdata = '0, data_rdata;
   logic [1:0] baud_cnt = '0;
   logic       xck_on = 0;
   logic [3:0] flen = 4'h9;
   int         fails = 0, checks_done = 0, nb = 8;
   logic [2:0] cs_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   logic [1:0] pm_tab [3] = '{2'h0, 2'h2, 2'h3};
   usdp_top i_usdp_top (.clk_sys, .nrst, .cfg, .tx_enable, .rx_enable, .tx_buffer_empty_irq_enable,
      .tx_complete_irq_enable, .global_irq_enable, .baud_en, .ext_transfer_clock_pin, .data_write,
      .data_wdata, .tx_ninth_bit, .tx_complete_clear, .tx_complete_ack, .data_read, .start_valid,
      .serial_in_pin, .data_rdata, .rx_ninth_bit, .frame_error_flag, .parity_error_flag, .overrun_flag,
      .rx_complete_flag, .tx_buffer_empty_flag, .tx_complete_flag, .tx_buffer_empty_irq, .tx_complete_irq,
      .serial_out_pin, .tx_pin_owned, .rx_pin_owned);
   usdp_remote i_usdp_remote (.clk_sys, .baud_en, .serial_out_pin, .frame_len(flen), .serial_in_pin,
      .start_valid);
   always #50 clk_sys = ~clk_sys;
   always @(negedge clk_sys)
   begin
      baud_cnt <= baud_cnt + 2'h1;
      baud_en  <= (baud_cnt == 2'h3);
      ext_transfer_clock_pin <= xck_on && (baud_cnt == 2'h3);
   end
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic setc(input logic [2:0] cs, input logic [1:0] pm, input logic ts);
      @(negedge clk_sys);
      cfg  = '{char_size: cs, parity_mode: pm, two_stop: ts, sync_mode: 1'h0};
      nb   = (cs == 3'h7) ? 9 : 5 + int'(cs);
      flen = 4'(nb + int'(pm[1]) + 1);
   endtask : setc
   function automatic logic [8:0] msk(input logic [8:0] d);
      return d & 9'((1 << nb) - 1);
   endfunction : msk
   function automatic logic [11:0] fr(input logic [8:0] d, input logic perr, input logic stp);
      logic [11:0] w;
      int          n;
      w = 12'(msk(d));
      n = nb;
      if (cfg.parity_mode[1])
      begin
         w[n] = ^msk(d) ^ cfg.parity_mode[0] ^ perr;
         n++;
      end
      w[n] = stp;
      return w;
   endfunction : fr
   task automatic wr(input logic [8:0] d);
      @(negedge clk_sys);
      data_write = 1'h1;
      {tx_ninth_bit, data_wdata} = d;
      @(negedge clk_sys);
      data_write = 1'h0;
      check("empty_flag", tx_buffer_empty_flag, 12'h0);
   endtask : wr
   task automatic wq(input int k);
      for (int t = 0; t < 2000 && i_usdp_remote.got.size() < k; t++) @(negedge clk_sys);
      check("frames", 12'(i_usdp_remote.got.size()), 12'(k));
   endtask : wq
   task automatic pop;
      data_read = 1'h1;
      @(negedge clk_sys);
      data_read = 1'h0;
      repeat (2) @(negedge clk_sys);
   endtask : pop
   task automatic rd(input logic [11:0] exp);
      check("rx_head", {frame_error_flag, parity_error_flag, overrun_flag, rx_ninth_bit, data_rdata}, exp);
      pop();
   endtask : rd
   task automatic rx(input logic [8:0] d, input logic perr, input logic stp);
      i_usdp_remote.send(fr(d, perr, stp), int'(flen) + int'(cfg.two_stop));
      repeat (3) @(negedge clk_sys);
   endtask : rx
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      complete_run();
   end
   initial
   begin
      repeat (5) @(negedge clk_sys);
      nrst = 1'h1;
      repeat (3) @(negedge clk_sys);
      check("idle_line", serial_out_pin, 12'h1);
      check("empty_flag", tx_buffer_empty_flag, 12'h1);
      check("empty_irq", tx_buffer_empty_irq, 12'h1);
      $display("test reset done");
      for (int i = 0; i < 3; i++)
      begin
         setc(cs_tab[2 * i], pm_tab[i], 1'h0);
         wr(9'h1A5 ^ 9'(i));
         wq(i + 1);
         check("tx_frame", i_usdp_remote.got[i], fr(9'h1A5 ^ 9'(i), 1'h0, 1'h1));
         repeat (2) @(negedge clk_sys);
         check("done_flag", tx_complete_flag, 12'h1);
         check("done_irq", tx_complete_irq, 12'h1);
         tx_complete_ack   = (i == 0);
         tx_complete_clear = (i != 0);
         @(negedge clk_sys);
         {tx_complete_ack, tx_complete_clear} = 2'h0;
         check("done_clear", tx_complete_flag, 12'h0);
      end
      setc(3'h3, 2'h0, 1'h0);
      wr(9'h0C3);
      for (int t = 0; t < 200 && !tx_buffer_empty_flag; t++) @(negedge clk_sys);
      wr(9'h03C);
      tx_enable = 1'h0;
      check("tx_owned", tx_pin_owned, 12'h1);
      wq(5);
      check("tx_frame", i_usdp_remote.got[3], fr(9'h0C3, 1'h0, 1'h1));
      check("tx_frame", i_usdp_remote.got[4], fr(9'h03C, 1'h0, 1'h1));
      repeat (4) @(negedge clk_sys);
      check("tx_owned", tx_pin_owned, 12'h0);
      $display("test transmit done");
      rx_enable = 1'h1;
      for (int i = 0; i < 5; i++)
      begin
         setc(cs_tab[i], 2'h3, 1'h1);
         rx(9'h15A, 1'h0, 1'h1);
         check("rx_flag", rx_complete_flag, 12'h1);
         rd(12'(msk(9'h15A)));
      end
      setc(3'h3, 2'h2, 1'h0);
      rx(9'h011, 1'h0, 1'h1);
      rx(9'h022, 1'h1, 1'h1);
      rx(9'h033, 1'h0, 1'h1);
      rx(9'h044, 1'h0, 1'h1);
      rd(12'h011);
      rd(12'h422);
      check("overrun", overrun_flag, 12'h1);
      pop();
      check("rx_flag", rx_complete_flag, 12'h0);
      rx(9'h0AA, 1'h0, 1'h0);
      rd(12'h8AA);
      rx(9'h055, 1'h0, 1'h1);
      rx_enable = 1'h0;
      repeat (2) @(negedge clk_sys);
      check("rx_flag", rx_complete_flag, 12'h0);
      check("rx_owned", rx_pin_owned, 12'h0);
      rx_enable = 1'h1;
      cfg.sync_mode = 1'h1;
      rx(9'h066, 1'h0, 1'h1);
      check("rx_flag", rx_complete_flag, 12'h0);
      xck_on = 1'h1;
      rx(9'h077, 1'h0, 1'h1);
      rd(12'h077);
      $display("test receive done");
      complete_run();
   end
endmodule : uart_tx_rx_datapath_flags_test
`default_nettype wire
